// File: rtl/ars_consts.vh
// constants for the amplifier reset and register-default block
// assumes inclusion by ars_reset_ctrl.v only, not by ars_sync.v
`ifndef ARS_CONSTS_VH
`define ARS_CONSTS_VH
// bank geometry
`define ARS_ADDR_W 3
`define ARS_DATA_W 8
`define ARS_NUM_REGS 8
// address of the control byte holding software shutdown
`define ARS_ADDR_CTRL 3'h0
// bit positions inside the control byte
`define ARS_BIT_SWSD 0
`define ARS_BIT_SPK_EN 1
`define ARS_BIT_HP_EN 2
// address of the limiter byte and lock bit position
`define ARS_ADDR_LIM 3'h1
`define ARS_BIT_LOCK 7
// default of the control byte: shutdown set, amplifiers off
`define ARS_CTRL_DEFAULT 8'h01
// default of every other byte
`define ARS_OTHER_DEFAULT 8'h00
// minimum valid reset low time in microseconds, clock in MHz
`define ARS_RESET_MIN_US 1000
`define ARS_CLK_MHZ 100
`endif

// File: rtl/ars_reset_ctrl.v
// reset control and default-valued register bank of the amplifier
// assumes a two-wire slave front end presenting one-cycle write/read strobes on CLK
// Function
// - while reset is low the amplifiers are off and every register holds its default.
// - reset clears the limiter write lock so the limiter byte can be written again.
// - register writes are refused while reset is low and accepted once it is high, except limiter-byte writes while its lock bit is set.
// - after reset the device starts in software shutdown with that bit set.
`timescale 1ns/100ps
`default_nettype none
`include "ars_consts.vh"
module ars_reset_ctrl #(
  parameter MIN_LOW_CYCLES = `ARS_RESET_MIN_US * `ARS_CLK_MHZ
) (
  // clock and logic reset
  input wire CLK,
  input wire RESET_N,
  // device reset pin, asynchronous to CLK
  input wire RST_PIN_N,
  // register write and read from the bus front end
  input wire WR_EN,
  input wire [`ARS_ADDR_W-1:0] WR_ADDR,
  input wire [`ARS_DATA_W-1:0] WR_DATA,
  input wire RD_EN,
  input wire [`ARS_ADDR_W-1:0] RD_ADDR,
  output reg [`ARS_DATA_W-1:0] RD_DATA,
  output reg RD_VALID,
  // status and amplifier controls
  output reg WR_REFUSED,
  output reg IN_RESET,
  output reg RESET_VALID,
  output reg SOFTWARE_SHUTDOWN,
  output reg LIMITER_WRITE_LOCK,
  output reg SPK_ENABLE,
  output reg HP_ENABLE,
  output reg [`ARS_DATA_W-2:0] LIMITER_SETTING
);
  reg [`ARS_DATA_W-1:0] bank [0:`ARS_NUM_REGS-1];
  reg [31:0] low_count;
  reg was_low;
  wire pin_level;
  wire pin_low;
  wire wr_ok;
  wire lim_frozen;
  integer i;
  // next values of the registered outputs
  reg [`ARS_DATA_W-1:0] next_rd_data;
  reg next_rd_valid;
  reg next_wr_refused;
  reg next_in_reset;
  reg next_sd;
  reg next_lock;
  reg next_spk;
  reg next_hp;
  reg [`ARS_DATA_W-2:0] next_lim;
  // reset values of the bank kept in one place
  localparam [`ARS_DATA_W-1:0] other_def = `ARS_OTHER_DEFAULT;
  localparam [`ARS_DATA_W-1:0] ctrl_def = `ARS_CTRL_DEFAULT;

  // default value of one register address
  function [`ARS_DATA_W-1:0] reg_default;
    input [`ARS_ADDR_W-1:0] a;
    begin
      if (a == `ARS_ADDR_CTRL) begin
        reg_default = `ARS_CTRL_DEFAULT;
      end else begin
        reg_default = `ARS_OTHER_DEFAULT;
      end
    end
  endfunction

  // amplifier enable: never in reset or software shutdown
  function amp_on;
    input held;
    input [`ARS_DATA_W-1:0] ctrl;
    input integer en_bit;
    begin
      amp_on = !held && !ctrl[`ARS_BIT_SWSD] && ctrl[en_bit];
    end
  endfunction

  // true when a write aims at the limiter byte while it is locked
  function lim_write_blocked;
    input [`ARS_ADDR_W-1:0] a;
    input [`ARS_DATA_W-1:0] lim_byte;
    begin
      lim_write_blocked = (a == `ARS_ADDR_LIM) && lim_byte[`ARS_BIT_LOCK];
    end
  endfunction

  // pin synchroniser
  ars_sync u_sync (
    .clk(CLK),
    .reset_n(RESET_N),
    .pin(RST_PIN_N),
    .level(pin_level)
  );

  // pin low or logic reset both hold the device in reset
  assign pin_low = !RESET_N || !pin_level;
  // limiter byte is frozen while its lock bit is set
  assign lim_frozen = lim_write_blocked(WR_ADDR, bank[`ARS_ADDR_LIM]);
  // writes land only outside reset; a write during reset is lost, not queued
  assign wr_ok = !pin_low && WR_EN && !lim_frozen;

  // register bank: defaults while reset low, writes only when high
  always @(posedge CLK) begin
    if (pin_low) begin
      for (i = 0; i < `ARS_NUM_REGS; i = i + 1) begin
        bank[i] <= reg_default(i[`ARS_ADDR_W-1:0]);
      end
    end else if (wr_ok) begin
      bank[WR_ADDR] <= WR_DATA;
    end
  end

  // low-time measurement for the valid-reset flag
  always @(posedge CLK) begin
    if (!RESET_N) begin
      low_count <= 32'h0000_0000;
      was_low <= 1'b0;
      RESET_VALID <= 1'b0;
    end else if (!pin_level) begin
      was_low <= 1'b1;
      if (low_count < MIN_LOW_CYCLES) begin
        low_count <= low_count + 32'h0000_0001;
      end
    end else begin
      if (was_low) begin
        RESET_VALID <= (low_count >= MIN_LOW_CYCLES);
      end
      was_low <= 1'b0;
      low_count <= 32'h0000_0000;
    end
  end

  // next output values
  // pin_low gates shutdown, lock and both enables (not the limiter setting) so the amps drop in the same cycle
  // as the bank reload, before the stale bank bits could leak out
  always @* begin
    next_rd_valid = RD_EN;
    next_rd_data = other_def;
    if (RD_EN) begin
      next_rd_data = bank[RD_ADDR]; // same-cycle write: old value read
    end
    next_wr_refused = WR_EN && !wr_ok;
    next_in_reset = pin_low;
    next_sd = pin_low | bank[`ARS_ADDR_CTRL][`ARS_BIT_SWSD];
    next_lock = !pin_low & bank[`ARS_ADDR_LIM][`ARS_BIT_LOCK];
    next_spk = amp_on(pin_low, bank[`ARS_ADDR_CTRL], `ARS_BIT_SPK_EN);
    next_hp = amp_on(pin_low, bank[`ARS_ADDR_CTRL], `ARS_BIT_HP_EN);
    next_lim = bank[`ARS_ADDR_LIM][`ARS_DATA_W-2:0];
  end

  // read port: data only while valid, zero otherwise
  always @(posedge CLK) begin
    if (!RESET_N) begin
      RD_DATA <= other_def;
      RD_VALID <= 1'b0;
    end else begin
      RD_DATA <= next_rd_data;
      RD_VALID <= next_rd_valid;
    end
  end

  // one-cycle pulse for a dropped write
  always @(posedge CLK) begin
    if (!RESET_N) begin
      WR_REFUSED <= 1'b0;
    end else begin
      WR_REFUSED <= next_wr_refused;
    end
  end

  // reset status and software shutdown
  // shutdown comes up set so the amps stay quiet until software clears it
  always @(posedge CLK) begin
    if (!RESET_N) begin
      IN_RESET <= 1'b1;
      SOFTWARE_SHUTDOWN <= ctrl_def[`ARS_BIT_SWSD];
    end else begin
      IN_RESET <= next_in_reset;
      SOFTWARE_SHUTDOWN <= next_sd;
    end
  end

  // limiter lock and setting
  always @(posedge CLK) begin
    if (!RESET_N) begin
      LIMITER_WRITE_LOCK <= other_def[`ARS_BIT_LOCK];
      LIMITER_SETTING <= other_def[`ARS_DATA_W-2:0];
    end else begin
      LIMITER_WRITE_LOCK <= next_lock;
      LIMITER_SETTING <= next_lim;
    end
  end

  // amplifier enables, off in reset or software shutdown
  always @(posedge CLK) begin
    if (!RESET_N) begin
      SPK_ENABLE <= 1'b0;
      HP_ENABLE <= 1'b0;
    end else begin
      SPK_ENABLE <= next_spk;
      HP_ENABLE <= next_hp;
    end
  end
endmodule // ars_reset_ctrl
`default_nettype wire

// File: rtl/ars_sync.v
// three-flop synchroniser for the external reset pin
// assumes one clock domain, CLK, and a pin from outside it
`timescale 1ns/100ps
`default_nettype none
module ars_sync (
  input wire clk,
  input wire reset_n,
  input wire pin,
  output reg level
);
  reg s1;
  reg s2;
  reg s3;
  // three stages; level changes when the second and third agree
  always @(posedge clk) begin
    if (!reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule // ars_sync
`default_nettype wire

// File: verification/ars_host_model.sv
// host side model driving the device reset pin
// assumes CLK from the bench
`timescale 1ns/100ps
`default_nettype none
module ars_host_model (
  // clock in, reset pin out
  input wire CLK,
  output logic RST_PIN_N
);
  // pin held low until the supplies count as settled
  initial RST_PIN_N = 0;
  // low for n cycles, then high
  task automatic pulse(int n);
    @(posedge CLK);
    #1 RST_PIN_N = 0;
    repeat (n) @(posedge CLK);
    #1 RST_PIN_N = 1;
  endtask
endmodule // ars_host_model
`default_nettype wire

// File: verification/ars_reset_ctrl_monitor.sv
// checker on the reset block ports
// assumes a bind onto ars_reset_ctrl
`timescale 1ns/100ps
`default_nettype none
module ars_reset_ctrl_monitor (
  // clock, write strobe, status
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic WR_EN,
  input wire logic WR_REFUSED,
  input wire logic IN_RESET,
  input wire logic SOFTWARE_SHUTDOWN,
  input wire logic LIMITER_WRITE_LOCK,
  input wire logic SPK_ENABLE,
  input wire logic HP_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // outputs while held and at release
  property p_off; IN_RESET [*2] |-> !SPK_ENABLE && !HP_ENABLE; endproperty
  property p_lock; IN_RESET [*2] |-> !LIMITER_WRITE_LOCK; endproperty
  property p_ref; WR_EN ##1 IN_RESET |-> WR_REFUSED; endproperty
  property p_sd; $fell(IN_RESET) |-> SOFTWARE_SHUTDOWN; endproperty
  a_off: assert property (p_off) else $error("amp on");
  a_lock: assert property (p_lock) else $error("lock set");
  a_ref: assert property (p_ref) else $error("write taken");
  a_sd: assert property (p_sd) else $error("not shut down");
  c_ref: cover property (WR_REFUSED);
  c_rel: cover property ($fell(IN_RESET));
  c_on: cover property (SPK_ENABLE);
endmodule // ars_reset_ctrl_monitor
bind ars_reset_ctrl ars_reset_ctrl_monitor ars_reset_ctrl_monitor_i (.CLK, .RESET_N, .WR_EN,
  .WR_REFUSED, .IN_RESET, .SOFTWARE_SHUTDOWN, .LIMITER_WRITE_LOCK, .SPK_ENABLE, .HP_ENABLE);
`default_nettype wire

// File: verification/ars_reset_ctrl_tb.sv
// bench of the amplifier reset block
// assumes the host model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module ars_reset_ctrl_tb;
  logic CLK = 0, RESET_N = 0, WR_EN = 0, rf;
  logic [2:0] WR_ADDR = 0;
  logic [7:0] WR_DATA = 0;
  logic RD_EN = 0;
  logic [2:0] RD_ADDR = 0;
  logic [7:0] got;
  wire pin, rp, ir, vl, sd, lk, sp, hp;
  wire [6:0] lim;
  wire rv;
  wire [7:0] rdd;
  int err_total = 0, num_checks = 0, cyc = 0;
  // 100 MHz clock
  always #5 CLK = ~CLK;
  ars_host_model ars_host_model_i (.CLK, .RST_PIN_N(pin));
  ars_reset_ctrl #(.MIN_LOW_CYCLES(20)) ars_reset_ctrl_i (.CLK, .RESET_N, .RST_PIN_N(pin),
    .WR_EN, .WR_ADDR, .WR_DATA, .RD_EN, .RD_ADDR, .RD_DATA(rdd), .RD_VALID(rv),
    .WR_REFUSED(rp), .IN_RESET(ir), .RESET_VALID(vl), .SOFTWARE_SHUTDOWN(sd),
    .LIMITER_WRITE_LOCK(lk), .SPK_ENABLE(sp), .HP_ENABLE(hp), .LIMITER_SETTING(lim));
  // compare one byte
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // one write; refusal kept, outputs settled on return
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge CLK);
    #1 {WR_EN, WR_ADDR, WR_DATA} = {1'b1, a, d};
    @(posedge CLK);
    #1 WR_EN = 0;
    rf = rp;
    repeat (2) @(posedge CLK);
    #1;
  endtask
  // one read; byte taken while RD_VALID stands, unknown if not valid
  task automatic rd(logic [2:0] a, output logic [7:0] v);
    @(posedge CLK);
    #1 {RD_EN, RD_ADDR} = {1'b1, a};
    @(posedge CLK);
    #1 RD_EN = 0;
    v = rv ? rdd : 8'hxx;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // start state, enables, locked limiter
  task automatic t_prog;
    chk("boot", 8'h01, sd);
    wr(3'h0, 8'h06);
    chk("enables", 8'h03, {sd, hp, sp});
    wr(3'h5, 8'h5a);
    rd(3'h5, got);
    chk("scratch", 8'h5a, got);
    wr(3'h1, 8'h85);
    wr(3'h1, 8'h03);
    chk("locked", 8'h85, {lk, lim});
    chk("refused", 8'h01, rf);
    $display("prog done");
  endtask
  // pin reset mid-run with a write inside it
  task automatic t_rst;
    fork
      ars_host_model_i.pulse(25);
      begin
        repeat (8) @(posedge CLK);
        wr(3'h0, 8'h06);
        chk("held", 8'h38, {rf, ir, sd, hp, sp, lk});
      end
    join
    repeat (8) @(posedge CLK);
    #1 chk("released", 8'h0a, {vl, ir, sd, lk});
    wr(3'h1, 8'h03);
    chk("limiter", 8'h03, {lk, lim});
    $display("reset done");
  endtask
  // bank reads after the pin reset: defaults back, limiter writable
  task automatic t_read;
    rd(3'h0, got);
    chk("ctrl byte", 8'h01, got);
    rd(3'h5, got);
    chk("other byte", 8'h00, got);
    rd(3'h1, got);
    chk("limiter byte", 8'h03, got);
    $display("read done");
  endtask
  // short low pulse still resets but is not reported valid
  task automatic t_short;
    wr(3'h0, 8'h06);
    ars_host_model_i.pulse(5);
    repeat (8) @(posedge CLK);
    #1 chk("short", 8'h01, {vl, ir, sd});
    $display("short done");
  endtask
  // cycle ceiling
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      wrap_up;
    end
  end
  // power-up, then scenarios
  initial begin
    repeat (12) @(posedge CLK);
    #1 RESET_N = 1;
    ars_host_model_i.pulse(20);
    repeat (8) @(posedge CLK);
    #1;
    t_prog;
    t_rst;
    t_read;
    t_short;
    wrap_up;
  end
endmodule // ars_reset_ctrl_tb
`default_nettype wire
